// file: logic/spc_pkg.sv
package spc_pkg;
	// sleep mode select codes
	localparam logic [2:0] SM_IDLE    = 3'h0;
	localparam logic [2:0] SM_NOISE   = 3'h1;
	localparam logic [2:0] SM_PDOWN   = 3'h2;
	localparam logic [2:0] SM_STANDBY = 3'h4;
	// timing
	localparam int CLK_MHZ          = 20;
	localparam int WAKE_HALT_CYC    = 4;
	localparam int OSC_START_CYC    = 6;
	localparam int BOD_WAKE_US      = 60;
	localparam int BOD_WAKE_CYC     = BOD_WAKE_US * CLK_MHZ;
	localparam int UNLOCK_WIN_CYC   = 4;
	localparam int CNT_W            = 12;
	// unlock signature, arbitrary value
	localparam logic [7:0] UNLOCK_SIG = 8'hA5;
	// gate vector positions
	localparam int G_CONV  = 0;
	localparam int G_TIM0  = 1;
	localparam int G_TIM1  = 2;
	localparam int G_SPI   = 3;
	localparam int G_TWI   = 4;
	localparam int N_GATES = 5;
	// states
	typedef enum logic [4:0] {
		ST_ACTIVE = 5'h01,
		ST_SLEEP  = 5'h02,
		ST_OSC    = 5'h04,
		ST_BODW   = 5'h08,
		ST_HALT   = 5'h10
	} spc_state_t;
endpackage

// file: logic/spc_cnt_if.sv
`timescale 1ns/1ps
// countdown request/status between the controller and its timer
interface spc_cnt_if;
	logic                      load;
	logic [spc_pkg::CNT_W-1:0] value;
	logic                      done;
	modport ctl (output load, output value, input done);
	modport tmr (input load, input value, output done);
endinterface

// file: logic/spc_timer.sv
`timescale 1ns/1ps
module spc_timer
(
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	// control
	spc_cnt_if.tmr    cnt
);
	typedef struct packed {
		logic [spc_pkg::CNT_W-1:0] count;
		logic                      done;
	} spc_tmr_t;
	spc_tmr_t s_q;
	spc_tmr_t s_d;

	// load restarts, done pulses in the cycle after the count steps from one to zero
	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (cnt.load)
			s_d.count = cnt.value;
		else if (s_q.count != '0)
		begin
			s_d.count = s_q.count - 1'b1;
			s_d.done  = (s_q.count == {{(spc_pkg::CNT_W-1){1'b0}}, 1'b1});
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign cnt.done = s_q.done;
endmodule

// file: logic/spc_ctrl.sv
`timescale 1ns/1ps
//
// Contract
// - sleep entered only with sleep_enable set and sleep instruction executed
// - code 000 Idle: stop core and memory clocks, rest runs
// - code 001 noise-reduction: stop io, core, memory; converter and oscillator run
// - code 010 Power-down: oscillator and all generated clocks stop
// - code 100 Standby: as Power-down but oscillator keeps running
// - Power-down wakes only on watchdog, level irq zero, pin change, address match
// - Idle wakes on any interrupt; noise-reduction also on converter complete
// - deep modes: irq zero wakes only when level-configured
// - deep modes: two-wire slave wakes only via address match
// - after wake core halted four cycles beyond start-up, then resumes
// - wake leaves register file and data memory untouched
// - reset during sleep wakes device and restarts at reset vector
// - converter enabled: entering Idle or noise-reduction starts a conversion
// - comparator power-off set: comparator cannot wake from Idle
// - brownout_sleep_off: detector off in Power-down/Standby, back on at wake
// - wake after detector off stretched to about 60 us
// - brownout_sleep_off resets zero; setting it needs the unlock sequence
// - power-reduction bit set: peripheral clock stopped, state frozen, access blocked
// - clearing power-reduction bit restores clock, peripheral resumes unchanged
// - per-peripheral gating matters only in Active and Idle; the code also applies the converter bit in noise-reduction
// - set brownout_sleep_off within four cycles after unlock signature write
// - brownout_sleep_off clears on wake or by plain zero write
// - gate bits for two-wire, serial, timer one, timer zero, converter
// - codes 011, 101, 110, 111 are reserved and never sleep
//
module spc_ctrl
#(
	parameter int BOD_WAKE_CYCLES = spc_pkg::BOD_WAKE_CYC
)
(
	// clock and reset
	input  wire logic                        clk_in,
	input  wire logic                        rst_in,
	// core control register bits
	input  wire logic                        sleep_enable_in,
	input  wire logic [2:0]                  sleep_mode_select_in,
	input  wire logic                        sleep_instr_in,
	// change protection and brownout bit writes
	input  wire logic                        change_protect_wr_in,
	input  wire logic [7:0]                  change_protect_data_in,
	input  wire logic                        bod_sleep_wr_in,
	input  wire logic                        bod_sleep_data_in,
	// power reduction register
	input  wire logic [spc_pkg::N_GATES-1:0] power_reduction_reg_in,
	// peripheral status
	input  wire logic                        conv_enabled_in,
	input  wire logic                        comparator_power_off_in,
	// wake sources
	input  wire logic                        wake_watchdog_in,
	input  wire logic                        wake_irq0_in,
	input  wire logic                        irq0_level_mode_in,
	input  wire logic                        wake_pin_change_in,
	input  wire logic                        wake_twi_addr_in,
	input  wire logic                        wake_twi_other_in,
	input  wire logic                        wake_conv_done_in,
	input  wire logic                        wake_comparator_in,
	input  wire logic                        wake_other_io_in,
	// clock enables
	output logic                             core_clock_domain_out,
	output logic                             memory_clock_domain_out,
	output logic                             io_clock_domain_out,
	output logic                             converter_clock_domain_out,
	output logic                             main_osc_en_out,
	output logic [spc_pkg::N_GATES-1:0]      periph_clk_en_out,
	// status and events
	output logic                             brownout_detector_en_out,
	output logic                             brownout_sleep_off_out,
	output logic                             core_halted_out,
	output logic                             conv_start_out,
	output logic                             wake_irq_out,
	output logic                             sleeping_out
);
	typedef struct packed {
		spc_pkg::spc_state_t state;
		logic [2:0]          mode;
		logic                brownout_sleep_off;
		logic                bod_was_off;
		logic [2:0]          unlock_cnt;
		logic                core_clk;
		logic                mem_clk;
		logic                io_clk;
		logic                conv_clk;
		logic                osc;
		logic [spc_pkg::N_GATES-1:0] pclk;
		logic                bod_en;
		logic                conv_start;
		logic                wake_pulse;
		logic                halted;
		logic                asleep;
	} spc_ctrl_t;

	spc_ctrl_t   s_q;
	spc_ctrl_t   s_d;
	spc_cnt_if   cnt ();
	logic        mode_ok;
	logic        wake_hit;
	logic        unlocked;

	spc_timer u_timer
	(
		.clk_in (clk_in),
		.rst_in (rst_in),
		.cnt    (cnt)
	);

	// ------------------------------------------------------------
	// mode and wake qualification
	// ------------------------------------------------------------
	// reserved codes are refused so a stray write never stalls the core
	always_comb
	begin
		mode_ok = (sleep_mode_select_in == spc_pkg::SM_IDLE)  ||
		          (sleep_mode_select_in == spc_pkg::SM_NOISE) ||
		          (sleep_mode_select_in == spc_pkg::SM_PDOWN) ||
		          (sleep_mode_select_in == spc_pkg::SM_STANDBY);
	end

	// deep modes share one restricted source set; noise-reduction adds converter complete
	always_comb
	begin
		wake_hit = wake_watchdog_in || wake_pin_change_in || wake_twi_addr_in
		         || (wake_irq0_in && irq0_level_mode_in);
		unique case (s_q.mode)
			spc_pkg::SM_IDLE:
				wake_hit = wake_watchdog_in || wake_pin_change_in || wake_irq0_in
				         || wake_twi_addr_in || wake_twi_other_in
				         || wake_conv_done_in || wake_other_io_in
				         || (wake_comparator_in && !comparator_power_off_in);
			spc_pkg::SM_NOISE:
				wake_hit = wake_hit || wake_conv_done_in;
			default:
				wake_hit = wake_hit;
		endcase
	end

	// unlock window open while the counter runs
	assign unlocked = (s_q.unlock_cnt != 3'h0);

	// timer load on wake, chosen by mode and detector state
	always_comb
	begin
		cnt.load  = 1'b0;
		cnt.value = '0;
		if (s_q.state == spc_pkg::ST_SLEEP && wake_hit)
		begin
			cnt.load = 1'b1;
			if (s_q.mode == spc_pkg::SM_PDOWN)
				cnt.value = spc_pkg::CNT_W'(spc_pkg::OSC_START_CYC);
			else if (s_q.bod_was_off)
				cnt.value = spc_pkg::CNT_W'(BOD_WAKE_CYCLES);
			else
				cnt.value = spc_pkg::CNT_W'(spc_pkg::WAKE_HALT_CYC);
		end
		else if (s_q.state == spc_pkg::ST_OSC && cnt.done)
		begin
			cnt.load = 1'b1;
			if (s_q.bod_was_off)
				cnt.value = spc_pkg::CNT_W'(BOD_WAKE_CYCLES);
			else
				cnt.value = spc_pkg::CNT_W'(spc_pkg::WAKE_HALT_CYC);
		end
		else if (s_q.state == spc_pkg::ST_BODW && cnt.done)
		begin
			cnt.load  = 1'b1;
			cnt.value = spc_pkg::CNT_W'(spc_pkg::WAKE_HALT_CYC);
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	// register file and memory are never touched here, only clocks and the brownout detector stop
	always_comb
	begin
		s_d = s_q;
		s_d.conv_start = 1'b0;
		s_d.wake_pulse = 1'b0;
		// protected write window
		if (change_protect_wr_in && change_protect_data_in == spc_pkg::UNLOCK_SIG)
			s_d.unlock_cnt = 3'(spc_pkg::UNLOCK_WIN_CYC);
		else if (unlocked)
			s_d.unlock_cnt = s_q.unlock_cnt - 3'h1;
		if (bod_sleep_wr_in)
		begin
			if (!bod_sleep_data_in)
				s_d.brownout_sleep_off = 1'b0;
			else if (unlocked)
				s_d.brownout_sleep_off = 1'b1;
		end
		unique case (s_q.state)
			spc_pkg::ST_ACTIVE:
			begin
				// without sleep_enable the instruction falls through
				if (sleep_instr_in && sleep_enable_in && mode_ok)
				begin
					s_d.state    = spc_pkg::ST_SLEEP;
					s_d.mode     = sleep_mode_select_in;
					s_d.core_clk = 1'b0;
					s_d.mem_clk  = 1'b0;
					if (sleep_mode_select_in != spc_pkg::SM_IDLE)
						s_d.io_clk = 1'b0;
					if (sleep_mode_select_in == spc_pkg::SM_PDOWN ||
					    sleep_mode_select_in == spc_pkg::SM_STANDBY)
					begin
						s_d.conv_clk = 1'b0;
						if (s_d.brownout_sleep_off)
						begin
							s_d.bod_en      = 1'b0;
							s_d.bod_was_off = 1'b1;
						end
					end
					if (sleep_mode_select_in == spc_pkg::SM_PDOWN)
						s_d.osc = 1'b0;
					if ((sleep_mode_select_in == spc_pkg::SM_IDLE ||
					     sleep_mode_select_in == spc_pkg::SM_NOISE) && conv_enabled_in)
						s_d.conv_start = 1'b1;
				end
			end
			spc_pkg::ST_SLEEP:
			begin
				if (wake_hit)
				begin
					s_d.wake_pulse = 1'b1;
					s_d.osc    = 1'b1;
					s_d.bod_en = 1'b1;
					s_d.brownout_sleep_off   = 1'b0;
					s_d.io_clk   = 1'b1;
					s_d.conv_clk = 1'b1;
					if (s_q.mode == spc_pkg::SM_PDOWN)
						s_d.state = spc_pkg::ST_OSC;
					else if (s_q.bod_was_off)
						s_d.state = spc_pkg::ST_BODW;
					else
						s_d.state = spc_pkg::ST_HALT;
				end
			end
			spc_pkg::ST_OSC:
				if (cnt.done)
					s_d.state = s_q.bod_was_off ? spc_pkg::ST_BODW : spc_pkg::ST_HALT;
			spc_pkg::ST_BODW:
				if (cnt.done)
					s_d.state = spc_pkg::ST_HALT;
			spc_pkg::ST_HALT:
				if (cnt.done)
				begin
					s_d.state       = spc_pkg::ST_ACTIVE;
					s_d.core_clk    = 1'b1;
					s_d.mem_clk     = 1'b1;
					s_d.bod_was_off = 1'b0;
				end
			default:
				s_d.state = spc_pkg::ST_ACTIVE;
		endcase
		// gating follows the register while io clock runs; the converter bit follows it while the converter clock runs
		s_d.pclk = s_d.io_clk ? ~power_reduction_reg_in : '0;
		if (!s_d.conv_clk)
			s_d.pclk[spc_pkg::G_CONV] = 1'b0;
		else if (!power_reduction_reg_in[spc_pkg::G_CONV])
			s_d.pclk[spc_pkg::G_CONV] = 1'b1;
		// status kept in flops so the core never sees a decode glitch
		s_d.halted = !s_d.core_clk;
		s_d.asleep = (s_d.state == spc_pkg::ST_SLEEP);
	end

	// reset always returns to active: restart from reset vector
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s_q            <= '0;
			s_q.state      <= spc_pkg::ST_ACTIVE;
			s_q.core_clk   <= 1'b1;
			s_q.mem_clk    <= 1'b1;
			s_q.io_clk     <= 1'b1;
			s_q.conv_clk   <= 1'b1;
			s_q.osc        <= 1'b1;
			s_q.bod_en     <= 1'b1;
			s_q.pclk       <= '1;
		end
		else
			s_q <= s_d;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign core_clock_domain_out      = s_q.core_clk;
	assign memory_clock_domain_out    = s_q.mem_clk;
	assign io_clock_domain_out        = s_q.io_clk;
	assign converter_clock_domain_out = s_q.conv_clk;
	assign main_osc_en_out            = s_q.osc;
	assign periph_clk_en_out          = s_q.pclk;
	assign brownout_detector_en_out   = s_q.bod_en;
	assign brownout_sleep_off_out     = s_q.brownout_sleep_off;
	assign core_halted_out            = s_q.halted;
	assign conv_start_out             = s_q.conv_start;
	assign wake_irq_out               = s_q.wake_pulse;
	assign sleeping_out               = s_q.asleep;
endmodule

// file: bench/spc_chk.sv
`timescale 1ns/1ps
// ----------
// sleep controller port checker
// ----------
module spc_chk
(
	// clock and reset
	input wire logic       clk_in,
	input wire logic       rst_in,
	// requests
	input wire logic       sleep_enable_in,
	input wire logic [2:0] sleep_mode_select_in,
	input wire logic       sleep_instr_in,
	input wire logic       conv_enabled_in,
	input wire logic [4:0] power_reduction_reg_in,
	// observed outputs
	input wire logic       core_clock_domain_out,
	input wire logic       memory_clock_domain_out,
	input wire logic       io_clock_domain_out,
	input wire logic       converter_clock_domain_out,
	input wire logic       main_osc_en_out,
	input wire logic [4:0] periph_clk_en_out,
	input wire logic       brownout_detector_en_out,
	input wire logic       brownout_sleep_off_out,
	input wire logic       core_halted_out,
	input wire logic       conv_start_out,
	input wire logic       wake_irq_out,
	input wire logic       sleeping_out
);
	logic       ent;
	logic       ok_code;
	logic [4:0] want;
	logic [4:0] clk5;
	// a request that must be taken: enable set and the core running
	assign ent = sleep_instr_in && sleep_enable_in && !sleeping_out && !core_halted_out;
	assign ok_code = sleep_mode_select_in inside {3'h0, 3'h1, 3'h2, 3'h4};
	assign clk5 = {core_clock_domain_out, memory_clock_domain_out, io_clock_domain_out,
		converter_clock_domain_out, main_osc_en_out};
	// enables left running per mode: core, memory, io, converter, oscillator
	always_comb
	begin
		case (sleep_mode_select_in)
			spc_pkg::SM_IDLE:    want = 5'h07;
			spc_pkg::SM_NOISE:   want = 5'h03;
			spc_pkg::SM_STANDBY: want = 5'h01;
			default:             want = 5'h00;
		endcase
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	AST_NO_ENTRY: assert property (
		sleep_instr_in && !(sleep_enable_in && ok_code) && !sleeping_out |=> !sleeping_out)
		else $error("sleep entered without enable or on a reserved code");
	AST_MODE_CLOCKS: assert property (
		ent && ok_code |=> sleeping_out && clk5 == $past(want))
		else $error("wrong clock enables after sleep entry");
	AST_HALT: assert property ($fell(core_halted_out) |-> $past(core_halted_out, 4))
		else $error("core halt shorter than four cycles");
	AST_WAKE_HALT: assert property (wake_irq_out |-> core_halted_out [*4])
		else $error("core released less than four cycles after wake");
	AST_WAKE_CAUSE: assert property (
		wake_irq_out |-> $past(sleeping_out) && !sleeping_out)
		else $error("wake pulse outside a wake");
	AST_CONV_START: assert property (
		ent && conv_enabled_in && sleep_mode_select_in inside {3'h0, 3'h1} |=> conv_start_out)
		else $error("no conversion start on entry");
	AST_CONV_CAUSE: assert property (
		conv_start_out |-> $past(sleep_instr_in) && $past(conv_enabled_in) && sleeping_out)
		else $error("conversion start without sleep entry");
	AST_BOD_OFF: assert property (
		ent && brownout_sleep_off_out && sleep_mode_select_in inside {3'h2, 3'h4}
		|=> !brownout_detector_en_out)
		else $error("detector left on in deep sleep");
	AST_BOD_BACK: assert property (
		$rose(core_clock_domain_out) |-> brownout_detector_en_out && !brownout_sleep_off_out)
		else $error("detector state wrong at core release");
	// the first edge after reset still shows the reset value of the gate flops
	AST_GATE: assert property (
		!$past(rst_in) && io_clock_domain_out && $past(io_clock_domain_out)
		&& $stable(power_reduction_reg_in) |-> periph_clk_en_out == ~power_reduction_reg_in)
		else $error("peripheral clock gating mismatch");
endmodule

bind spc_ctrl spc_chk u_chk (.clk_in, .rst_in, .sleep_enable_in, .sleep_mode_select_in,
	.sleep_instr_in, .conv_enabled_in, .power_reduction_reg_in, .core_clock_domain_out,
	.memory_clock_domain_out, .io_clock_domain_out, .converter_clock_domain_out,
	.main_osc_en_out, .periph_clk_en_out, .brownout_detector_en_out, .brownout_sleep_off_out,
	.core_halted_out, .conv_start_out, .wake_irq_out, .sleeping_out);

// file: bench/spc_core_model.sv
`timescale 1ns/1ps
// ----------
// core and wake source model
// ----------
module spc_core_model
(
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// bench requests
	input  wire logic       go_in,
	input  wire logic [7:0] raise_in,
	// controller status
	input  wire logic       core_clk_in,
	input  wire logic       halted_in,
	// to controller
	output logic            sleep_instr_out,
	output logic [7:0]      wake_out
);
	// a stopped core cannot execute, so sleep only issues with its clock running
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sleep_instr_out <= 1'b0;
			wake_out <= 8'h00;
		end
		else
		begin
			sleep_instr_out <= go_in && core_clk_in && !sleep_instr_out;
			// levels hold until the handler runs, else a wake could be lost
			if (core_clk_in && !halted_in)
				wake_out <= raise_in;
			else
				wake_out <= wake_out | raise_in;
		end
	end
endmodule

// file: bench/tb.sv
`timescale 1ns/1ps
// ----------
// sleep controller testbench
// ----------
module tb;
	localparam int BODC = 20;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic sleep_enable_in = 1'b0;
	logic [2:0] sleep_mode_select_in = 3'h0;
	logic change_protect_wr_in = 1'b0;
	logic [7:0] change_protect_data_in = 8'h00;
	logic bod_sleep_wr_in = 1'b0;
	logic bod_sleep_data_in = 1'b0;
	logic [4:0] power_reduction_reg_in = 5'h00;
	logic conv_enabled_in = 1'b0;
	logic comparator_power_off_in = 1'b0;
	logic irq0_level_mode_in = 1'b1;
	logic go = 1'b0;
	logic [7:0] raise = 8'h00;
	logic [7:0] wk;
	logic sleep_instr_in;
	logic [4:0] clk5;
	logic [4:0] periph_clk_en_out;
	logic core_clock_domain_out, memory_clock_domain_out, io_clock_domain_out;
	logic converter_clock_domain_out, main_osc_en_out, brownout_detector_en_out;
	logic brownout_sleep_off_out, core_halted_out, conv_start_out, wake_irq_out, sleeping_out;
	logic [31:0] rng = 32'h620A;
	logic woke;
	logic bsel;
	int failures = 0;
	int n_tests = 0;
	int cyc;
	int lo;

	assign clk5 = {core_clock_domain_out, memory_clock_domain_out, io_clock_domain_out,
		converter_clock_domain_out, main_osc_en_out};
	// 50 ns period
	always #25 clk_in = ~clk_in;

	spc_ctrl #(.BOD_WAKE_CYCLES(BODC)) dut (.clk_in, .rst_in, .sleep_enable_in,
		.sleep_mode_select_in, .sleep_instr_in, .change_protect_wr_in, .change_protect_data_in,
		.bod_sleep_wr_in, .bod_sleep_data_in, .power_reduction_reg_in, .conv_enabled_in,
		.comparator_power_off_in, .wake_watchdog_in(wk[0]), .wake_irq0_in(wk[1]),
		.irq0_level_mode_in, .wake_pin_change_in(wk[2]), .wake_twi_addr_in(wk[3]),
		.wake_twi_other_in(wk[4]), .wake_conv_done_in(wk[5]), .wake_comparator_in(wk[6]),
		.wake_other_io_in(wk[7]), .core_clock_domain_out, .memory_clock_domain_out,
		.io_clock_domain_out, .converter_clock_domain_out, .main_osc_en_out, .periph_clk_en_out,
		.brownout_detector_en_out, .brownout_sleep_off_out, .core_halted_out, .conv_start_out,
		.wake_irq_out, .sleeping_out);
	spc_core_model core (.clk_in, .rst_in, .go_in(go), .raise_in(raise),
		.core_clk_in(core_clock_domain_out), .halted_in(core_halted_out),
		.sleep_instr_out(sleep_instr_in), .wake_out(wk));

	// ----------
	// helpers
	// ----------
	task automatic tick(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	task automatic summarize();
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function automatic logic [31:0] rnd();
		return {rng[30:0], rng[31] ^ rng[21] ^ rng[1] ^ rng[0]};
	endfunction
	// running enables per mode: core, memory, io, converter, oscillator
	function automatic logic [4:0] want(input logic [2:0] m);
		return (m == 3'h0) ? 5'h07 : (m == 3'h1) ? 5'h03 : (m == 3'h4) ? 5'h01 : 5'h00;
	endfunction
	// sources: watchdog, irq0, pin change, address match, other two-wire, conv, comp, io
	function automatic logic wakes(input logic [2:0] m, input logic [2:0] s,
		input logic lvl, input logic acd);
		if (m == spc_pkg::SM_IDLE)
			return !(s == 3'h6 && acd);
		return s == 3'h0 || s == 3'h2 || s == 3'h3 || (s == 3'h1 && lvl)
			|| (s == 3'h5 && m == spc_pkg::SM_NOISE);
	endfunction
	task automatic do_sleep();
		go = 1'b1;
		tick(1);
		go = 1'b0;
		tick(3);
	endtask
	task automatic wake(input logic [7:0] m);
		raise = m;
		tick(1);
		raise = 8'h00;
		for (int k = 0; k < 12 && sleeping_out === 1'b1; k++)
			tick(1);
		woke = sleeping_out === 1'b0;
	endtask
	task automatic resume();
		for (cyc = 0; cyc < 200 && core_clock_domain_out !== 1'b1; cyc++)
			tick(1);
	endtask
	// signature write, a gap, then the sleep-off write
	task automatic brownout_sleep_off(input logic [7:0] sig, input int gap, input logic d);
		change_protect_wr_in = 1'b1;
		change_protect_data_in = sig;
		tick(1);
		change_protect_wr_in = 1'b0;
		tick(gap);
		bod_sleep_wr_in = 1'b1;
		bod_sleep_data_in = d;
		tick(1);
		bod_sleep_wr_in = 1'b0;
		tick(1);
	endtask

	// ----------
	// main sequence
	// ----------
	initial
	begin
		tick(4);
		rst_in = 1'b0;
		chk({clk5, brownout_detector_en_out, brownout_sleep_off_out, sleeping_out}, 8'hFC,
			"reset values");
		// good unlock, plain clear, bad signature, late write
		for (int i = 0; i < 4; i++)
		begin
			brownout_sleep_off((i == 0 || i == 3) ? 8'hA5 : 8'h5A, (i == 3) ? 6 : 1, i != 1);
			chk(brownout_sleep_off_out, i == 0, "sleep-off write");
		end
		// every mode code, then one sleep with the enable clear
		for (int i = 0; i < 9; i++)
		begin
			rng = rnd();
			sleep_mode_select_in = (i < 8) ? i[2:0] : spc_pkg::SM_PDOWN;
			sleep_enable_in = i < 8;
			power_reduction_reg_in = rng[4:0];
			// software stops the converter before gating its clock
			conv_enabled_in = rng[5] && !rng[0];
			// standby always takes the detector-off path so it is never skipped
			bsel = rng[6] || i == 4;
			brownout_sleep_off(8'hA5, 1, bsel);
			do_sleep();
			chk(sleeping_out, i < 3 || i == 4, "entry");
			if (sleeping_out === 1'b1)
			begin
				chk(clk5, want(i[2:0]), "mode clocks");
				chk(brownout_detector_en_out, !(bsel && i[2:1] != 2'h0), "detector");
				if (i == 0)
					chk(periph_clk_en_out, {3'h0, ~power_reduction_reg_in}, "idle gating");
				lo = 3 + ((i == 2) ? 6 : 0) + ((bsel && i[2:1] != 2'h0) ? BODC : 0);
				wake(8'h01);
				resume();
				chk(cyc >= lo && cyc <= lo + 8, 1'b1, "wake time");
				chk({brownout_detector_en_out, brownout_sleep_off_out}, 8'h02, "woken");
			end
			chk(periph_clk_en_out, {3'h0, ~power_reduction_reg_in}, "gating");
		end
		// random wake sources against every valid mode
		sleep_enable_in = 1'b1;
		for (int i = 0; i < 48; i++)
		begin
			rng = rnd();
			sleep_mode_select_in = (rng[1:0] == 2'h3) ? spc_pkg::SM_STANDBY : {1'b0, rng[1:0]};
			irq0_level_mode_in = rng[5];
			comparator_power_off_in = rng[6];
			conv_enabled_in = rng[7] && !power_reduction_reg_in[spc_pkg::G_CONV];
			do_sleep();
			wake(8'h01 << rng[4:2]);
			bsel = wakes(sleep_mode_select_in, rng[4:2], rng[5], rng[6]);
			chk(woke, bsel, "source");
			if (woke !== 1'b1)
				wake(8'h01);
			resume();
		end
		// reset while asleep in power-down
		sleep_mode_select_in = spc_pkg::SM_PDOWN;
		do_sleep();
		rst_in = 1'b1;
		tick(1);
		chk({clk5, sleeping_out}, 8'h3E, "reset in sleep");
		rst_in = 1'b0;
		tick(2);
		chk({clk5, sleeping_out}, 8'h3E, "after reset");
		summarize();
	end

	// hang guard, well beyond the fewer than two thousand cycles the sequence needs
	initial
	begin
		#1000000;
		failures++;
		summarize();
	end
endmodule
